// ==== rtl/qnc_pkg.sv ====
`default_nettype none
package qnc_pkg;
   // ==========================================================
   // link widths
   localparam int MAG_W   = 15;
   localparam int PHASE_W = 32;
   localparam int OUT_W   = 16;
   localparam int SEL_W   = 2;

   // angle bus target codes
   localparam logic [1:0] SEL_NONE = 2'h0;
   localparam logic [1:0] SEL_DEV  = 2'h1;
   localparam logic [1:0] SEL_TUNE = 2'h2;
   localparam logic [1:0] SEL_BOTH = 2'h3;

   // ==========================================================
   // pipeline
   localparam int PIPE_DEPTH = 22;
   localparam int CORDIC_N   = 16;
   localparam int CORDIC_W   = 18;
   localparam int ANGLE_W    = 16;
   // cordic gain compensation, 0.60725 in 1.15 fixed point
   localparam logic [15:0] GAIN_COMP = 16'h4DBB;
   localparam logic [15:0] HALF_TURN = 16'h8000;
   // atan(2^-i) in units of 2^-16 turn
   localparam logic [15:0] ATAN_TAB [0:15] = '{
      16'h2000, 16'h12E4, 16'h09FB, 16'h0511,
      16'h028B, 16'h0146, 16'h00A3, 16'h0051,
      16'h0029, 16'h0014, 16'h000A, 16'h0005,
      16'h0003, 16'h0001, 16'h0001, 16'h0000};
   localparam logic signed [17:0] SAT_HI = 18'sh0_7FFF;
   localparam logic signed [17:0] SAT_LO = -18'sh0_8000;

   // ==========================================================
   // host register map (apb, byte addresses)
   localparam int          ADDR_W     = 8;
   localparam logic [7:0]  ADDR_CTRL  = 8'h00;
   localparam logic [7:0]  ADDR_MAG   = 8'h04;
   localparam logic [7:0]  ADDR_TUNE  = 8'h08;
   localparam logic [7:0]  ADDR_DEV   = 8'h0C;
   localparam logic [7:0]  ADDR_FIFO  = 8'h10;
   localparam logic [7:0]  ADDR_STAT  = 8'h14;
   localparam int          CTRL_FM    = 0;
   localparam int          CTRL_PM    = 1;
   localparam int          CTRL_STRM  = 2;
   localparam logic [2:0]  CTRL_RESET = 3'h0;
   localparam int          STAT_EMPTY = 0;
   localparam int          STAT_FULL  = 1;
   localparam int          STAT_CNT   = 8;

   // ==========================================================
   // sample fifo
   localparam int FIFO_WIDTH = 32;
   localparam int FIFO_DEPTH = 16;
   localparam int FIFO_CNT_W = 5;

   typedef logic [1:0] qnc_sel_type;
endpackage : qnc_pkg
`default_nettype wire

// ==== rtl/qnc_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface qnc_if;
   logic [14:0] magnitude_input;
   logic        gain_load_strobe;
   logic [31:0] angle_input_bus;
   logic [1:0]  angle_bus_target_sel;
   logic        freq_mod_select;
   logic        angle_offset_mode;

   modport dev (
      input magnitude_input, gain_load_strobe, angle_input_bus,
            angle_bus_target_sel, freq_mod_select, angle_offset_mode
   );
   modport host (
      output magnitude_input, gain_load_strobe, angle_input_bus,
             angle_bus_target_sel, freq_mod_select, angle_offset_mode
   );
endinterface : qnc_if
`default_nettype wire

// ==== rtl/qnc_device.sv ====
// Functional notes
// R1: strobe high captures magnitude at rising edge
// R2: strobe held high recaptures magnitude every edge
// R3: outputs scale magnitude, binary point at bit 15
// R4: 32-bit tuning word is per-clock phase step
// R5: target 10 loads angle bus into tuning
// R6: both modes low holds phase, standby
// R7: frequency mode adds tuning plus deviation
// R8: offset mode adds deviation after accumulator
// R9: target 00 leaves tuning and deviation alone
// R10: host loads or clears deviation first
// R11: target 01 loads deviation every edge
// R12: phase is binary fraction of a turn
// R13: accumulator wraps silently modulo two to 32
// R14: host switches modes of all devices together
// R15: twenty-two register stages input to output
// R16: real is amp cosine, sine is amp sine
// R17: only upper sixteen phase bits converted
// R18: inputs and outputs registered, one pair per clock
`timescale 1ns/10ps
`default_nettype none
module qnc_device (
   input  wire logic        i_clk,      // system clock
   input  wire logic        i_reset,    // sync reset, active high
   qnc_if.dev               link,       // control from host
   output logic      [15:0] o_real,     // amplitude times cosine
   output logic      [15:0] o_sine      // amplitude times sine
);
   localparam int N = qnc_pkg::CORDIC_N;
   localparam int W = qnc_pkg::CORDIC_W;

   // ==========================================================
   // stage 1: input registers
   logic [14:0] amp_reg;
   logic [31:0] tune_reg;
   logic [31:0] dev_reg;
   logic        fm_reg;
   logic        pm_reg;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         amp_reg <= 15'h0000;
      end else if (link.gain_load_strobe) begin
         amp_reg <= link.magnitude_input; // R1 R2 R18
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         tune_reg <= 32'h0000_0000;
         dev_reg  <= 32'h0000_0000;
      end else begin
         // 00 holds both registers R9
         if (link.angle_bus_target_sel[1]) begin
            tune_reg <= link.angle_input_bus; // R5 R4
         end
         if (link.angle_bus_target_sel[0]) begin
            dev_reg <= link.angle_input_bus; // R11
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         fm_reg <= 1'b0;
         pm_reg <= 1'b0;
      end else begin
         fm_reg <= link.freq_mod_select; // R18
         pm_reg <= link.angle_offset_mode;
      end
   end

   // ==========================================================
   // stage 2: phase accumulator
   logic [31:0] acc_reg;
   logic [31:0] acc_next;
   logic [31:0] dev_d2;
   logic        pm_d2;
   logic [14:0] amp_d2;

   always_comb begin
      // plain 32-bit sums wrap, no saturation R13 R12
      case ({fm_reg, pm_reg})
         2'b10:   acc_next = acc_reg + tune_reg + dev_reg; // R7
         2'b01:   acc_next = acc_reg + tune_reg; // R8
         default: acc_next = acc_reg; // R6
      endcase
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         acc_reg <= 32'h0000_0000;
         dev_d2  <= 32'h0000_0000;
         pm_d2   <= 1'b0;
         amp_d2  <= 15'h0000;
      end else begin
         acc_reg <= acc_next;
         dev_d2  <= dev_reg;
         pm_d2   <= pm_reg & ~fm_reg;
         amp_d2  <= amp_reg;
      end
   end

   // ==========================================================
   // stage 3: offset outside the accumulation loop
   logic [31:0] sum_reg;
   logic [14:0] amp_d3;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         sum_reg <= 32'h0000_0000;
         amp_d3  <= 15'h0000;
      end else begin
         sum_reg <= pm_d2 ? acc_reg + dev_d2 : acc_reg; // R8
         amp_d3  <= amp_d2;
      end
   end

   // ==========================================================
   // stage 4: fold to +-90 degrees and prescale gain
   logic        [15:0]      phase_top;
   logic        [30:0]      gain_prod;
   logic signed [W-1:0]     gain_x;
   logic        [15:0]      fold_z;
   logic signed [W-1:0]     cx [0:N];
   logic signed [W-1:0]     cy [0:N];
   logic signed [W-1:0]     cz [0:N];

   assign phase_top = sum_reg[31:16]; // R17
   assign gain_prod = {16'h0000, amp_d3} * {15'h0, qnc_pkg::GAIN_COMP};
   assign gain_x    = $signed({2'b00, gain_prod[30:15]});
   assign fold_z    = phase_top - qnc_pkg::HALF_TURN;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         cx[0] <= 18'sh0_0000;
         cy[0] <= 18'sh0_0000;
         cz[0] <= 18'sh0_0000;
      end else if (phase_top[15] ^ phase_top[14]) begin
         // rear half: start from the opposite vector
         cx[0] <= -gain_x;
         cy[0] <= 18'sh0_0000;
         cz[0] <= $signed({{2{fold_z[15]}}, fold_z});
      end else begin
         cx[0] <= gain_x;
         cy[0] <= 18'sh0_0000;
         cz[0] <= $signed({{2{phase_top[15]}}, phase_top});
      end
   end

   // ==========================================================
   // stages 5 to 20: rotation, one micro step per stage
   for (genvar i = 0; i < N; i++) begin : g_rot
      logic signed [W-1:0] atan_s;
      assign atan_s = $signed({2'b00, qnc_pkg::ATAN_TAB[i]});
      always_ff @(posedge i_clk) begin
         if (i_reset) begin
            cx[i+1] <= 18'sh0_0000;
            cy[i+1] <= 18'sh0_0000;
            cz[i+1] <= 18'sh0_0000;
         end else if (!cz[i][W-1]) begin
            cx[i+1] <= cx[i] - (cy[i] >>> i);
            cy[i+1] <= cy[i] + (cx[i] >>> i);
            cz[i+1] <= cz[i] - atan_s;
         end else begin
            cx[i+1] <= cx[i] + (cy[i] >>> i);
            cy[i+1] <= cy[i] - (cx[i] >>> i);
            cz[i+1] <= cz[i] + atan_s;
         end
      end
   end

   // ==========================================================
   // stages 21 and 22: clamp and output registers
   function automatic logic [15:0] qnc_sat(input logic signed [17:0] v);
      logic [15:0] r;
      r = v[15:0];
      if (v > qnc_pkg::SAT_HI) begin
         r = 16'h7FFF;
      end else if (v < qnc_pkg::SAT_LO) begin
         r = 16'h8000;
      end
      return r;
   endfunction : qnc_sat

   logic [15:0] sat_x_reg;
   logic [15:0] sat_y_reg;

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         sat_x_reg <= 16'h0000;
         sat_y_reg <= 16'h0000;
      end else begin
         // rounding growth may pass full scale by a few lsb
         sat_x_reg <= qnc_sat(cx[N]); // R3
         sat_y_reg <= qnc_sat(cy[N]);
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_real <= 16'h0000;
         o_sine <= 16'h0000;
      end else begin
         o_real <= sat_x_reg; // R16 R15 R18
         o_sine <= sat_y_reg;
      end
   end
endmodule : qnc_device
`default_nettype wire

// ==== rtl/qnc_host.sv ====
// Chosen here: the APB register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module qnc_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input  wire logic                       i_clk,       // clock
   input  wire logic                       i_reset,     // sync reset
   input  wire logic                       i_in_valid,  // push request
   output logic                            o_in_ready,  // not full
   input  wire logic [WIDTH-1:0]           i_in_data,   // push data
   output logic                            o_out_valid, // not empty
   input  wire logic                       i_out_ready, // pop request
   output logic      [WIDTH-1:0]           o_out_data,  // head word
   output logic      [$clog2(DEPTH):0]     o_count      // words held
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW-1:0]    wr_ptr_reg;
   logic [AW-1:0]    rd_ptr_reg;
   logic [AW:0]      cnt_reg;
   logic             push;
   logic             pop;

   assign o_in_ready  = (cnt_reg != (AW+1)'(DEPTH));
   assign o_out_valid = (cnt_reg != '0);
   assign push        = i_in_valid & o_in_ready;
   assign pop         = i_out_ready & o_out_valid;
   assign o_out_data  = mem[rd_ptr_reg];
   assign o_count     = cnt_reg;

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_ptr_reg] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         cnt_reg    <= '0;
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + AW'(1);
         end
         if (pop) begin
            rd_ptr_reg <= rd_ptr_reg + AW'(1);
         end
         if (push && !pop) begin
            cnt_reg <= cnt_reg + (AW+1)'(1);
         end else if (pop && !push) begin
            cnt_reg <= cnt_reg - (AW+1)'(1);
         end
      end
   end
endmodule : qnc_fifo

module qnc_host (
   input  wire logic        i_clk,      // system clock
   input  wire logic        i_reset,    // sync reset, active high
   input  wire logic        i_psel,     // apb select
   input  wire logic        i_penable,  // apb access phase
   input  wire logic        i_pwrite,   // apb write
   input  wire logic [7:0]  i_paddr,    // apb byte address
   input  wire logic [31:0] i_pwdata,   // apb write data
   output logic      [31:0] o_prdata,   // apb read data
   output logic             o_pready,   // apb ready
   output logic             o_pslverr,  // apb error, unmapped
   qnc_if.host              link        // control to device
);
   logic [2:0]  ctrl_reg;
   logic [14:0] mag_reg;
   logic        strobe_reg;
   logic [31:0] angle_reg;
   logic [1:0]  sel_reg;
   logic        init_done_reg;
   logic        access;
   logic        wr;
   logic        mapped;
   logic        wr_tune;
   logic        wr_dev;
   logic        fifo_in_ready;
   logic        fifo_out_valid;
   logic        fifo_out_ready;
   logic [31:0] fifo_out_data;
   logic [4:0]  fifo_count;
   logic [31:0] prdata_next;

   // ==========================================================
   // apb decode
   assign access  = i_psel & i_penable;
   assign mapped  = (i_paddr == qnc_pkg::ADDR_CTRL) | (i_paddr == qnc_pkg::ADDR_MAG)
                  | (i_paddr == qnc_pkg::ADDR_TUNE) | (i_paddr == qnc_pkg::ADDR_DEV)
                  | (i_paddr == qnc_pkg::ADDR_FIFO) | (i_paddr == qnc_pkg::ADDR_STAT);
   // a full fifo stalls the bus until the stream drains a word
   assign o_pready  = (i_pwrite && i_paddr == qnc_pkg::ADDR_FIFO) ? fifo_in_ready : 1'b1;
   assign o_pslverr = access & ~mapped;
   assign wr        = access & i_pwrite & o_pready;
   assign wr_tune   = wr & (i_paddr == qnc_pkg::ADDR_TUNE);
   assign wr_dev    = wr & (i_paddr == qnc_pkg::ADDR_DEV);

   always_comb begin
      prdata_next = 32'h0000_0000;
      case (i_paddr)
         qnc_pkg::ADDR_CTRL: prdata_next[2:0] = ctrl_reg;
         qnc_pkg::ADDR_MAG:  prdata_next[14:0] = mag_reg;
         qnc_pkg::ADDR_TUNE: prdata_next = angle_reg;
         qnc_pkg::ADDR_STAT: begin
            prdata_next[qnc_pkg::STAT_EMPTY] = ~fifo_out_valid;
            prdata_next[qnc_pkg::STAT_FULL]  = ~fifo_in_ready;
            prdata_next[qnc_pkg::STAT_CNT +: qnc_pkg::FIFO_CNT_W] = fifo_count;
         end
         default:            prdata_next = 32'h0000_0000;
      endcase
   end

   // captured in the setup cycle, so read data is a flop and stands through access
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         o_prdata <= 32'h0000_0000;
      end else if (i_psel && !i_penable) begin
         o_prdata <= prdata_next;
      end
   end

   // ==========================================================
   // modulation sample fifo
   assign fifo_out_ready = ctrl_reg[qnc_pkg::CTRL_STRM] & init_done_reg & ~wr_tune & ~wr_dev;

   qnc_fifo #(
      .WIDTH (qnc_pkg::FIFO_WIDTH),
      .DEPTH (qnc_pkg::FIFO_DEPTH)
   ) u_fifo (
      .i_clk       (i_clk),
      .i_reset     (i_reset),
      .i_in_valid  (access & i_pwrite & (i_paddr == qnc_pkg::ADDR_FIFO)),
      .o_in_ready  (fifo_in_ready),
      .i_in_data   (i_pwdata),
      .o_out_valid (fifo_out_valid),
      .i_out_ready (fifo_out_ready),
      .o_out_data  (fifo_out_data),
      .o_count     (fifo_count)
   );

   // ==========================================================
   // mode and amplitude
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         ctrl_reg <= qnc_pkg::CTRL_RESET;
      end else if (wr && i_paddr == qnc_pkg::ADDR_CTRL) begin
         ctrl_reg <= i_pwdata[2:0]; // R14
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         mag_reg    <= 15'h0000;
         strobe_reg <= 1'b0;
      end else begin
         strobe_reg <= wr && i_paddr == qnc_pkg::ADDR_MAG; // R1
         if (wr && i_paddr == qnc_pkg::ADDR_MAG) begin
            mag_reg <= i_pwdata[14:0];
         end
      end
   end

   // ==========================================================
   // angle bus: bus writes first, then stream samples
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         angle_reg     <= 32'h0000_0000;
         sel_reg       <= qnc_pkg::SEL_NONE;
         init_done_reg <= 1'b0;
      end else if (!init_done_reg) begin
         // deviation is undefined until written, so clear it once
         angle_reg     <= 32'h0000_0000; // R10
         sel_reg       <= qnc_pkg::SEL_DEV;
         init_done_reg <= 1'b1;
      end else if (wr_tune) begin
         angle_reg <= i_pwdata;
         sel_reg   <= qnc_pkg::SEL_TUNE; // R5
      end else if (wr_dev) begin
         angle_reg <= i_pwdata;
         sel_reg   <= qnc_pkg::SEL_DEV; // R11
      end else if (fifo_out_ready && fifo_out_valid) begin
         angle_reg <= fifo_out_data;
         sel_reg   <= qnc_pkg::SEL_DEV; // R11
      end else begin
         sel_reg <= qnc_pkg::SEL_NONE; // R9
      end
   end

   assign link.magnitude_input      = mag_reg;
   assign link.gain_load_strobe     = strobe_reg;
   assign link.angle_input_bus      = angle_reg;
   assign link.angle_bus_target_sel = sel_reg;
   assign link.freq_mod_select      = ctrl_reg[qnc_pkg::CTRL_FM];
   assign link.angle_offset_mode    = ctrl_reg[qnc_pkg::CTRL_PM];
endmodule : qnc_host
`default_nettype wire

// ==== tb/qnc_link_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module qnc_link_assertions (
   input wire logic        i_clk,                // clock
   input wire logic        i_reset,              // sync reset
   input wire logic [14:0] magnitude_input,      // amplitude
   input wire logic        gain_load_strobe,     // amplitude load
   input wire logic [31:0] angle_input_bus,      // angle word
   input wire logic [1:0]  angle_bus_target_sel, // angle target
   input wire logic        freq_mod_select,      // fm mode
   input wire logic        angle_offset_mode,    // pm mode
   input wire logic [15:0] o_real,               // cosine out
   input wire logic [15:0] o_sine                // sine out
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);

   // ==========================================================
   // idle run length, saturating
   logic [4:0] idle_reg;
   wire logic  idle = (freq_mod_select == angle_offset_mode) && !gain_load_strobe &&
                      (angle_bus_target_sel == qnc_pkg::SEL_NONE);

   always_ff @(posedge i_clk) begin
      if (i_reset || !idle) begin
         idle_reg <= 5'h00;
      end else if (idle_reg != 5'h1F) begin
         idle_reg <= idle_reg + 5'h01;
      end
   end

   // ==========================================================
   // assertions
   chk_reset_zero_out: assert property ($fell(i_reset) |-> o_real == 16'h0000 && o_sine == 16'h0000)
      else $error("outputs not zero after reset");
   chk_reset_link_idle: assert property ($fell(i_reset) |-> !gain_load_strobe && !freq_mod_select
                                         && !angle_offset_mode)
      else $error("link not idle after reset");
   chk_deviation_clear: assert property ($fell(i_reset) |-> ##[0:1]
      (angle_bus_target_sel == qnc_pkg::SEL_DEV && angle_input_bus == 32'h0000_0000))
      else $error("deviation not cleared after reset");
   chk_strobe_one_cycle: assert property ($rose(gain_load_strobe) |=> !gain_load_strobe)
      else $error("strobe held longer than one cycle");
   chk_tune_one_cycle: assert property (angle_bus_target_sel == qnc_pkg::SEL_TUNE
                                        |=> angle_bus_target_sel != qnc_pkg::SEL_TUNE)
      else $error("tuning select held longer than one cycle");
   chk_angle_with_sel: assert property ($changed(angle_input_bus) |-> angle_bus_target_sel != qnc_pkg::SEL_NONE)
      else $error("angle bus moved with no target");
   chk_mag_with_strobe: assert property ($changed(magnitude_input) |-> gain_load_strobe)
      else $error("magnitude moved without strobe");
   // 25 idle cycles cover the full pipeline
   chk_standby_hold: assert property (idle_reg >= 5'h19 |-> $stable(o_real) && $stable(o_sine))
      else $error("outputs moved in standby");

   cov_fm_mode: cover property (freq_mod_select && !angle_offset_mode);
   cov_pm_mode: cover property (angle_offset_mode && !freq_mod_select);
   cov_strobe: cover property ($rose(gain_load_strobe));
   cov_long_idle: cover property (idle_reg == 5'h1F);
endmodule : qnc_link_assertions
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_fail++; \
   $display("Error at %0t: got %h expected %h", $time, got, exp); end end
module testbench;
   typedef struct packed {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] rd; logic er;} qnc_row_type;

   logic        i_clk, i_reset, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, rd;
   logic        er;
   wire  logic [31:0] prdata;
   wire  logic        pready, pslverr;
   wire  logic [15:0] o_real, o_sine;
   int          n_fail, checks_done, n, i;
   logic [15:0] old;
   qnc_row_type rows [10] = '{
      '{1'b1, qnc_pkg::ADDR_CTRL, 32'h0000_0000, 32'h0000_0000, 1'b0},
      '{1'b0, qnc_pkg::ADDR_CTRL, 32'h0000_0000, 32'h0000_0000, 1'b0},
      '{1'b1, qnc_pkg::ADDR_MAG,  32'h0000_4000, 32'h0000_0000, 1'b0},
      '{1'b0, qnc_pkg::ADDR_MAG,  32'h0000_0000, 32'h0000_4000, 1'b0},
      '{1'b1, qnc_pkg::ADDR_TUNE, 32'h2000_0000, 32'h0000_0000, 1'b0},
      '{1'b0, qnc_pkg::ADDR_TUNE, 32'h0000_0000, 32'h2000_0000, 1'b0},
      '{1'b0, qnc_pkg::ADDR_DEV,  32'h0000_0000, 32'h0000_0000, 1'b0},
      '{1'b0, qnc_pkg::ADDR_STAT, 32'h0000_0000, 32'h0000_0001, 1'b0},
      '{1'b1, 8'h18,              32'hFFFF_FFFF, 32'h0000_0000, 1'b1},
      '{1'b0, 8'h18,              32'h0000_0000, 32'h0000_0000, 1'b1}};

   qnc_if qnc_if_i ();
   qnc_host qnc_host_i (.i_clk(i_clk), .i_reset(i_reset), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .link(qnc_if_i));
   qnc_device qnc_device_i (.i_clk(i_clk), .i_reset(i_reset), .link(qnc_if_i), .o_real(o_real), .o_sine(o_sine));
   qnc_link_assertions qnc_link_assertions_i (.i_clk(i_clk), .i_reset(i_reset),
      .magnitude_input(qnc_if_i.magnitude_input), .gain_load_strobe(qnc_if_i.gain_load_strobe),
      .angle_input_bus(qnc_if_i.angle_input_bus), .angle_bus_target_sel(qnc_if_i.angle_bus_target_sel),
      .freq_mod_select(qnc_if_i.freq_mod_select), .angle_offset_mode(qnc_if_i.angle_offset_mode),
      .o_real(o_real), .o_sine(o_sine));

   // ==========================================================
   // helpers
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : tally_and_finish

   // one idle edge first, so release and next setup never share a time step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge i_clk);
      penable <= 1'b1;
      // only the watchdog ends a stalled access
      do begin
         @(posedge i_clk);
      end while (pready !== 1'b1);
      rd      = prdata;
      er      = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   function automatic logic near(input logic [15:0] g, input real e);
      real v;
      v = $itor($signed(g));
      near = !$isunknown(g) && (v - e) <= 12.0 && (e - v) <= 12.0;
   endfunction : near

   // each sample must be the previous one rotated by w turns
   task automatic rot(input real w);
      logic [15:0] r0, s0;
      real         c, s;
      c = $cos(6.283185307 * w);
      s = $sin(6.283185307 * w);
      repeat (30) @(posedge i_clk);
      #1;
      r0 = o_real;
      s0 = o_sine;
      repeat (12) begin
         @(posedge i_clk);
         #1;
         `CHK(near(o_real, $signed(r0) * c - $signed(s0) * s), 1'b1)
         `CHK(near(o_sine, $signed(r0) * s + $signed(s0) * c), 1'b1)
         r0 = o_real;
         s0 = o_sine;
      end
   endtask : rot

   // ==========================================================
   // clock, watchdog, tests
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end

   initial begin
      #200000;
      n_fail++;
      tally_and_finish();
   end

   initial begin
      {i_reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 43'h0};
      n_fail = 0;
      checks_done = 0;
      repeat (5) @(posedge i_clk);
      i_reset <= 1'b0;
      @(posedge i_clk);
      #1;
      `CHK(o_real, 16'h0000)
      foreach (rows[j]) begin
         apb(rows[j].wr, rows[j].a, rows[j].d);
         `CHK(er, rows[j].er)
         if (!rows[j].wr) `CHK(rd, rows[j].rd)
      end
      repeat (30) @(posedge i_clk);
      #1;
      `CHK(near(o_real, 16384.0), 1'b1)
      `CHK(near(o_sine, 0.0), 1'b1)
      apb(1'b1, qnc_pkg::ADDR_MAG, 32'h0000_2000);
      #1;
      `CHK(qnc_if_i.gain_load_strobe, 1'b1)
      old = o_real;
      n = 0;
      do begin
         @(posedge i_clk);
         #1;
         n++;
      end while (o_real === old && n < 40);
      `CHK(n, 22)
      repeat (5) @(posedge i_clk);
      #1;
      `CHK(near(o_real, 8192.0), 1'b1)
      apb(1'b1, qnc_pkg::ADDR_DEV, 32'h2000_0000);
      apb(1'b1, qnc_pkg::ADDR_CTRL, 32'h0000_0001);
      rot(0.25);
      apb(1'b1, qnc_pkg::ADDR_CTRL, 32'h0000_0002);
      rot(0.125);
      apb(1'b1, qnc_pkg::ADDR_CTRL, 32'h0000_0003);
      repeat (40) @(posedge i_clk);
      apb(1'b1, qnc_pkg::ADDR_CTRL, 32'h0000_0000);
      for (i = 0; i < 16; i++) apb(1'b1, qnc_pkg::ADDR_FIFO, i);
      apb(1'b0, qnc_pkg::ADDR_STAT, 32'h0000_0000);
      `CHK(rd, 32'h0000_1002)
      apb(1'b1, qnc_pkg::ADDR_CTRL, 32'h0000_0004);
      repeat (30) @(posedge i_clk);
      apb(1'b0, qnc_pkg::ADDR_STAT, 32'h0000_0000);
      `CHK(rd, 32'h0000_0001)
      i_reset <= 1'b1;
      repeat (5) @(posedge i_clk);
      i_reset <= 1'b0;
      @(posedge i_clk);
      #1;
      `CHK(o_sine, 16'h0000)
      apb(1'b0, qnc_pkg::ADDR_CTRL, 32'h0000_0000);
      `CHK(rd, 32'h0000_0000)
      tally_and_finish();
   end
endmodule : testbench
`default_nettype wire
